// File: common/cec_pkg.sv
/*
  Shared constants of the controller error classifier: register map,
  field positions, error codes and timing figures.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
`default_nettype none
package cec_pkg;
  // Core clock rate
  localparam int CLK_HZ = 100_000_000;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_AUX = 8'h08;
  localparam logic [7:0] OFF_ALARM = 8'h0c;
  // Control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_PROG = 2;
  // Status fields
  localparam int ST_CODE_LSB = 0;
  localparam int ST_UNIT_WAIT = 8;
  localparam int ST_REM_WAIT = 9;
  localparam int ST_RUN = 10;
  localparam int ST_PEND = 11;
  localparam int ST_FATAL = 12;
  localparam int ST_CNT_LSB = 16;
  // Auxiliary fields
  localparam int AUX_SPEC_LSB = 16;
  // Error codes, BCD or hex as shown to the operator
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_MAX_BCD = 8'h99;
  localparam logic [7:0] CODE_INTR = 8'h8a;
  localparam logic [7:0] CODE_ISR = 8'h8b;
  localparam logic [7:0] CODE_HD = 8'h9a;
  localparam logic [7:0] CODE_SETUP = 8'h9b;
  localparam logic [7:0] CODE_CASS = 8'h9d;
  localparam logic [7:0] CODE_OVR = 8'hf8;
  localparam logic [7:0] CODE_TABLE = 8'he7;
  localparam logic [7:0] CODE_REM0 = 8'hb0;
  localparam logic [7:0] CODE_REM1 = 8'hb1;
  localparam logic [7:0] CODE_SPEC = 8'hd0;
  localparam logic [7:0] CODE_BATT = 8'hf7;
  // Pin vector layout
  localparam int PIN_UNIT_WAIT = 0;
  localparam int PIN_REM_WAIT = 1;
  localparam int PIN_EVT_LSB = 2;
  localparam int PIN_SCAN_END = 12;
  localparam int PIN_FATAL = 13;
  localparam int PIN_HD_LSB = 14;
  localparam int PIN_SPEC_LSB = 18;
  localparam int PIN_W = 22;
  // Number of queued error sources (10 pins, overrun, alarm instruction)
  localparam int NSRC = 12;
  localparam int SRC_USER = 11;
  // Timing figures
  localparam int OVR_MS = 100;
  localparam int BLINK_MS = 250;
  // Controller modes
  typedef enum logic [1:0] {CEC_INIT, CEC_RUN, CEC_HALT} cec_mode_e;
endpackage
`default_nettype wire

// File: rtl/cec_top.sv
/*
  Controller error classifier: sorts detected conditions into waits,
  non-fatal and fatal errors, queues error codes for the status code field and
  drives the front indicators and the run output.
  Assumes an APB master on mclk and asynchronous condition pins.
*/
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
module cec_top
  import cec_pkg::*;
#(
  parameter int QDEPTH = 8, // Error queue depth
  parameter int OVR_CYC = OVR_MS * (CLK_HZ / 1000), // Scan overrun limit
  parameter int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000) // Half blink period
) (
  input wire logic mclk, // Core clock
  input wire logic arst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic unit_wait, // Special/interrupt unit not initialised
  input wire logic remote_wait, // Remote unit unpowered or no terminator
  input wire logic intr_xfer_err, // Interrupt unit transfer fault
  input wire logic isr_overlong, // Refresh subroutine too long
  input wire logic hd_xfer_err, // High-density unit transfer fault
  input wire logic setup_bad, // Bad setup value read or used
  input wire logic cassette_err, // Cassette transfer failure
  input wire logic table_mismatch, // I/O table mismatch
  input wire logic remote0_err, // Remote master 0 transmission fault
  input wire logic remote1_err, // Remote master 1 transmission fault
  input wire logic special_err, // Link or special unit fault
  input wire logic battery_low, // Battery missing or low
  input wire logic scan_end, // End of program scan
  input wire logic fatal_err, // Fatal condition, stops execution
  input wire logic [3:0] hd_unit, // Failing high-density unit
  input wire logic [3:0] special_unit, // Faulting special unit
  output logic power_led, // Power indicator
  output logic run_led, // Run indicator
  output logic alarm_error_indicator, // Alarm/error indicator
  output logic run_out, // Run output
  output logic exec_en // Program execution enable
);

  localparam int QW = $clog2(QDEPTH);
  localparam logic [QW:0] Q_FULL = (QW + 1)'(QDEPTH);
  // Raw pin vector, bit order fixed by the pin layout constants
  logic [PIN_W-1:0] pin_raw;
  assign pin_raw = {special_unit, hd_unit, fatal_err, scan_end, battery_low, special_err,
                    remote1_err, remote0_err, table_mismatch, cassette_err, setup_bad,
                    hd_xfer_err, isr_overlong, intr_xfer_err, remote_wait, unit_wait};
  logic [PIN_W-1:0] sync1_r; // First synchroniser stage
  logic [PIN_W-1:0] sync2_r; // Second synchroniser stage
  logic [PIN_W-1:0] prev_r; // Previous synchronised value
  logic [PIN_W-1:0] rise; // Rising edges

  // Two-flop synchroniser and edge detect per pin bit
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
          prev_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= pin_raw[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi] <= sync2_r[gi];
        end
      end
      assign rise[gi] = sync2_r[gi] & ~prev_r[gi];
    end
  endgenerate

  // Code for each queued source
  function automatic logic [7:0] src_code(input int idx, input logic [7:0] user);
    case (idx)
      0: src_code = CODE_INTR;
      1: src_code = CODE_ISR;
      2: src_code = CODE_HD;
      3: src_code = CODE_SETUP;
      4: src_code = CODE_CASS;
      5: src_code = CODE_TABLE;
      6: src_code = CODE_REM0;
      7: src_code = CODE_REM1;
      8: src_code = CODE_SPEC;
      9: src_code = CODE_BATT;
      10: src_code = CODE_OVR;
      default: src_code = user;
    endcase
  endfunction

  // APB decode
  logic wr_acc; // Write lands only at the edge that completes the transfer
  logic mapped; // Address hits a register
  assign wr_acc = psel & penable & pready & pwrite;
  assign mapped = (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
                  (paddr == OFF_AUX) || (paddr == OFF_ALARM);
  logic start_r; // Software start request
  logic prog_r; // Program mode flag
  logic [7:0] user_code_r; // Last alarm instruction code
  logic user_evt_r; // Alarm instruction posted a code
  logic pop_r; // Pop request from clear or code 00
  cec_mode_e mode_r; // Controller mode
  logic ovr_evt_r; // Scan overrun event
  logic [NSRC-1:0] pend_r; // Pending sources awaiting queue slot
  logic [7:0] q_mem [QDEPTH]; // Error code queue
  logic [QW-1:0] q_rd_r; // Queue read pointer
  logic [QW-1:0] q_wr_r; // Queue write pointer
  logic [QW:0] q_cnt_r; // Queue fill
  logic [15:0] hd_flags_r; // High-density unit flags
  logic [3:0] spec_unit_r; // Last faulting special unit
  logic [31:0] ovr_cnt_r; // Scan length counter
  logic [31:0] blink_cnt_r; // Blink divider
  logic blink_r; // Blink phase

  // Control writes and alarm instruction writes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      start_r <= 1'b0;
      prog_r <= 1'b1;
      user_code_r <= CODE_NONE;
      user_evt_r <= 1'b0;
      pop_r <= 1'b0;
    end else begin
      user_evt_r <= 1'b0;
      pop_r <= 1'b0;
      if (wr_acc && paddr == OFF_CTRL) begin
        start_r <= pwdata[CTRL_START];
        prog_r <= pwdata[CTRL_PROG];
        pop_r <= pwdata[CTRL_CLEAR];
      end
      if (wr_acc && paddr == OFF_ALARM) begin
        if (pwdata[7:0] == CODE_NONE) begin
          pop_r <= 1'b1;
        end else if (pwdata[7:4] <= CODE_MAX_BCD[7:4] &&
                     pwdata[3:0] <= CODE_MAX_BCD[3:0]) begin
          user_code_r <= pwdata[7:0];
          user_evt_r <= 1'b1;
        end
      end
    end
  end
  // Mode: waits hold start, non-fatal errors never leave run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= CEC_INIT;
    end else begin
      case (mode_r)
        CEC_INIT: begin
          if (sync2_r[PIN_FATAL]) begin
            mode_r <= CEC_HALT;
          end else if (start_r && !sync2_r[PIN_UNIT_WAIT] &&
                       !sync2_r[PIN_REM_WAIT]) begin
            mode_r <= CEC_RUN;
          end
        end
        CEC_RUN: begin
          if (sync2_r[PIN_FATAL]) begin
            mode_r <= CEC_HALT;
          end else if (!start_r) begin
            mode_r <= CEC_INIT;
          end
          // Queued non-fatal errors keep the scan running
        end
        CEC_HALT: begin
          if (!sync2_r[PIN_FATAL] && !start_r) begin
            mode_r <= CEC_INIT;
          end
        end
        default: mode_r <= CEC_INIT;
      endcase
    end
  end
  // Scan watchdog: counts cycles between scan ends while running
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_cnt_r <= 32'h0000_0000;
      ovr_evt_r <= 1'b0;
    end else begin
      ovr_evt_r <= 1'b0;
      if (mode_r != CEC_RUN || rise[PIN_SCAN_END]) begin
        ovr_cnt_r <= 32'h0000_0000;
      end else if (ovr_cnt_r <= 32'(OVR_CYC)) begin
        // Count parks one past the limit, so one overrun code per scan
        ovr_evt_r <= (ovr_cnt_r == 32'(OVR_CYC));
        ovr_cnt_r <= ovr_cnt_r + 32'h0000_0001;
      end
    end
  end
  // Event sources in queue priority order
  logic [NSRC-1:0] evt;
  assign evt = {user_evt_r, ovr_evt_r,
                rise[PIN_SCAN_END-1:PIN_EVT_LSB]};
  // Pick lowest pending source
  logic pick_v;
  logic [3:0] pick_i;
  always_comb begin
    pick_v = 1'b0;
    pick_i = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        pick_v = 1'b1;
        pick_i = 4'(i);
      end
    end
  end

  logic q_push;
  logic q_pop;
  assign q_push = pick_v && (q_cnt_r != Q_FULL);
  assign q_pop = pop_r && (q_cnt_r != '0);
  // Pending bits: a new event wins over the clear of its slot
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= '0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (evt[i]) begin
          pend_r[i] <= 1'b1;
        end else if (q_push && pick_i == 4'(i)) begin
          pend_r[i] <= 1'b0;
        end
      end
    end
  end
  // Queue storage and pointers
  always_ff @(posedge mclk) begin
    if (q_push) begin
      q_mem[q_wr_r] <= src_code(int'(pick_i), user_code_r);
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      q_rd_r <= '0;
      q_wr_r <= '0;
      q_cnt_r <= '0;
    end else begin
      if (q_push) begin
        q_wr_r <= q_wr_r + QW'(1);
      end
      if (q_pop) begin
        q_rd_r <= q_rd_r + QW'(1);
      end
      if (q_push && !q_pop) begin
        q_cnt_r <= q_cnt_r + (QW + 1)'(1);
      end else if (q_pop && !q_push) begin
        q_cnt_r <= q_cnt_r - (QW + 1)'(1);
      end
    end
  end
  // Auxiliary status: unit flags and faulting unit number
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hd_flags_r <= 16'h0000;
      spec_unit_r <= 4'h0;
    end else begin
      if (rise[PIN_EVT_LSB + 2]) begin
        hd_flags_r[sync2_r[PIN_HD_LSB +: 4]] <= 1'b1;
      end else if (q_pop && q_cnt_r == (QW + 1)'(1)) begin
        hd_flags_r <= 16'h0000;
      end
      if (rise[PIN_EVT_LSB + 8]) begin
        spec_unit_r <= sync2_r[PIN_SPEC_LSB +: 4];
      end
    end
  end
  // Blink divider for the alarm indicator
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= 1'b0;
    end else if (blink_cnt_r >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_r <= 32'h0000_0000;
      blink_r <= ~blink_r;
    end else begin
      blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
    end
  end
  // Indicators and run output
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_led <= 1'b0;
      run_led <= 1'b0;
      alarm_error_indicator <= 1'b0;
      run_out <= 1'b0;
      exec_en <= 1'b0;
    end else begin
      power_led <= 1'b1;
      run_led <= (mode_r == CEC_RUN);
      run_out <= (mode_r == CEC_RUN);
      exec_en <= (mode_r == CEC_RUN);
      alarm_error_indicator <= (mode_r == CEC_HALT) ||
                               ((q_cnt_r != '0) && blink_r);
    end
  end
  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFF_CTRL: begin
        rd_mux[CTRL_START] = start_r;
        rd_mux[CTRL_PROG] = prog_r;
      end
      OFF_STATUS: begin
        rd_mux[ST_CODE_LSB +: 8] = (q_cnt_r != '0) ? q_mem[q_rd_r] : CODE_NONE;
        rd_mux[ST_UNIT_WAIT] = sync2_r[PIN_UNIT_WAIT];
        rd_mux[ST_REM_WAIT] = sync2_r[PIN_REM_WAIT];
        rd_mux[ST_RUN] = (mode_r == CEC_RUN);
        rd_mux[ST_PEND] = (q_cnt_r != '0);
        rd_mux[ST_FATAL] = (mode_r == CEC_HALT);
        rd_mux[ST_CNT_LSB +: QW + 1] = q_cnt_r;
      end
      OFF_AUX: begin
        rd_mux[15:0] = hd_flags_r;
        rd_mux[AUX_SPEC_LSB +: 4] = spec_unit_r;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // APB answer: ready in the first access cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// File: tb/cec_console.sv
/*
  Console model: reads and clears error messages over APB.
  Assumes one APB slave on mclk.
*/
`default_nettype none
module cec_console (
  input wire logic mclk, // Clock
  output var logic psel, // APB select
  output var logic penable, // APB enable
  output var logic pwrite, // APB direction
  output var logic [7:0] paddr, // APB address
  output var logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; request held until ready is sampled
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the bench watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/cec_top_asserts.sv
/*
  Port checker of the error classifier: indicators, run output, APB.
  Assumes a short blink parameter in simulation.
*/
`default_nettype none
module cec_top_asserts #(
  parameter int BLINK_CYC = 4 // Half blink period
) (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic unit_wait, // Unit wait pin
  input wire logic remote_wait, // Remote wait pin
  input wire logic fatal_err, // Fatal pin
  input wire logic power_led, // Power indicator
  input wire logic run_led, // Run indicator
  input wire logic alarm_error_indicator, // Alarm indicator
  input wire logic run_out, // Run output
  input wire logic exec_en // Execution enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // Alarm must drop within one full blink period
  localparam int BLK_WIN = 2 * BLINK_CYC;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Steps of a bus request and of a held fault
  sequence s_setup; psel && !penable; endsequence
  sequence s_fatal; fatal_err[*6]; endsequence
  property p_power_on; $past(arst_n) |-> power_led; endproperty
  property p_off_dark; !exec_en |-> !run_out && !run_led; endproperty
  property p_unit_hold; (!exec_en && unit_wait)[*3] |=> !exec_en; endproperty
  property p_rem_hold; (!exec_en && remote_wait)[*3] |=> !exec_en; endproperty
  property p_blink;
    run_led && alarm_error_indicator |-> ##[1:BLK_WIN] (!alarm_error_indicator || !run_led);
  endproperty
  property p_exec_run; run_out |-> exec_en && run_led && power_led; endproperty
  property p_fatal; s_fatal |-> alarm_error_indicator && !run_out; endproperty
  property p_ready_cause; pready |-> $past(psel && !penable); endproperty
  property p_ready; s_setup |=> pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  a_power_on: assert property (p_power_on) else $error("power dark");
  a_off_dark: assert property (p_off_dark) else $error("run lit idle");
  a_unit_hold: assert property (p_unit_hold) else $error("unit wait ran");
  a_rem_hold: assert property (p_rem_hold) else $error("remote wait ran");
  a_blink: assert property (p_blink) else $error("alarm not blinking");
  a_exec_run: assert property (p_exec_run) else $error("run w/o exec");
  a_fatal: assert property (p_fatal) else $error("fatal not steady");
  a_ready_cause: assert property (p_ready_cause) else $error("stray ready");
  a_ready: assert property (p_ready) else $error("no ready");
  a_err: assert property (p_err) else $error("error w/o ready");
endmodule
bind cec_top cec_top_asserts #(.BLINK_CYC(BLINK_CYC)) i_cec_top_asserts (
  .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .unit_wait(unit_wait), .remote_wait(remote_wait),
  .fatal_err(fatal_err), .power_led(power_led), .run_led(run_led),
  .alarm_error_indicator(alarm_error_indicator), .run_out(run_out), .exec_en(exec_en));
`default_nettype wire

// File: tb/controller_error_classifier_bench.sv
/*
  Bench of the error classifier: event table, waits, queue, faults.
  Assumes the console model drives the register bus.
*/
`default_nettype none
module controller_error_classifier_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cec_pkg::*;
  typedef struct {logic [9:0] pin; logic [7:0] code; logic [31:0] am; logic [31:0] ax;} cec_row_s;
  logic mclk = 1'b0; // Clock
  logic arst_n = 1'b0; // Reset
  logic psel, penable, pwrite, pready, pslverr; // APB
  logic [7:0] paddr; // APB address
  logic [31:0] pwdata, prdata, q; // APB data
  logic [9:0] evt = '0; // Event pins
  logic [3:0] hd_unit = 4'h5, special_unit = 4'h9; // Unit number pins
  logic unit_wait = 1'b1, remote_wait = 1'b0, fatal_err = 1'b0; // Level pins
  logic scan_end = 1'b0, scan_on = 1'b1; // Scan pulses
  logic [4:0] scnt = '0; // Scan divider
  logic power_led, run_led, alarm_error_indicator, run_out, exec_en; // Indicators
  logic err; // Bus error seen
  logic [1:0] seen; // Alarm levels seen
  int fail_count = 0, num_checks = 0; // Tallies
  // Event rows: pin, head code, aux mask, aux value
  cec_row_s rows [10] = '{
    '{10'h001, CODE_INTR, 32'h0, 32'h0},
    '{10'h002, CODE_ISR, 32'h0, 32'h0},
    '{10'h004, CODE_HD, 32'hffff, 32'h20},
    '{10'h008, CODE_SETUP, 32'h0, 32'h0},
    '{10'h010, CODE_CASS, 32'h0, 32'h0},
    '{10'h020, CODE_TABLE, 32'h0, 32'h0},
    '{10'h040, CODE_REM0, 32'h0, 32'h0},
    '{10'h080, CODE_REM1, 32'h0, 32'h0},
    '{10'h100, CODE_SPEC, 32'hf0000, 32'h90000},
    '{10'h200, CODE_BATT, 32'h0, 32'h0}};
  always #5 mclk = ~mclk;
  // Scan end edge every 16 cycles while enabled
  always @(posedge mclk) begin
    scnt <= scnt + 5'h01;
    scan_end <= scan_on && scnt[3];
  end
  cec_top #(.QDEPTH(8), .OVR_CYC(50), .BLINK_CYC(4)) i_cec_top (
    .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .unit_wait(unit_wait), .remote_wait(remote_wait), .intr_xfer_err(evt[0]),
    .isr_overlong(evt[1]), .hd_xfer_err(evt[2]), .setup_bad(evt[3]), .cassette_err(evt[4]),
    .table_mismatch(evt[5]), .remote0_err(evt[6]), .remote1_err(evt[7]),
    .special_err(evt[8]), .battery_low(evt[9]), .scan_end(scan_end), .fatal_err(fatal_err),
    .hd_unit(hd_unit), .special_unit(special_unit), .power_led(power_led), .run_led(run_led),
    .alarm_error_indicator(alarm_error_indicator), .run_out(run_out), .exec_en(exec_en));
  cec_console i_cec_console (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Compare and tally
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_cec_console.xfer(1'b1, a, d, r, err);
    repeat (4) @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    i_cec_console.xfer(1'b0, a, 32'h0, q, err);
  endtask
  // Pulse event pins, then allow sync, edge and queue latency
  task automatic fire(input logic [9:0] m);
    evt <= m;
    repeat (3) @(posedge mclk);
    evt <= '0;
    repeat (12) @(posedge mclk);
  endtask
  // Head code and queue count in one read
  task automatic head(input logic [7:0] c, input logic [3:0] n);
    rd(OFF_STATUS);
    chk("head code", {24'h0, c}, {24'h0, q[7:0]});
    chk("queue count", {28'h0, n}, {28'h0, q[19:16]});
  endtask
  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (6000) @(posedge mclk);
    fail_count++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("leds idle", 32'h4, {29'h0, power_led, run_led, run_out});
    rd(OFF_STATUS);
    chk("status idle", 32'h100, q);
    wr(OFF_CTRL, 32'h5);
    repeat (6) @(posedge mclk);
    chk("unit wait holds", 32'h0, {29'h0, exec_en, run_led, run_out});
    remote_wait <= 1'b1;
    unit_wait <= 1'b0;
    repeat (6) @(posedge mclk);
    rd(OFF_STATUS);
    chk("remote wait", 32'h200, q & 32'h6ff);
    chk("remote holds", 32'h0, {29'h0, exec_en, run_led, run_out});
    remote_wait <= 1'b0;
    repeat (6) @(posedge mclk);
    chk("running", 32'h7, {29'h0, exec_en, run_led, run_out});
    $display("test waits done");
    for (int i = 0; i < 10; i++) begin
      fire(rows[i].pin);
      head(rows[i].code, 4'h1);
      rd(OFF_AUX);
      chk("aux field", rows[i].ax, q & rows[i].am);
      chk("run kept", 32'h7, {29'h0, exec_en, run_led, run_out});
      seen = 2'b00;
      repeat (12) @(posedge mclk) seen[alarm_error_indicator] = 1'b1;
      chk("alarm blinks", 32'h3, {30'h0, seen});
      wr(OFF_CTRL, 32'h7);
      head(CODE_NONE, 4'h0);
      $display("test row %0d done", i);
    end
    wr(OFF_ALARM, 32'h42);
    wr(OFF_ALARM, 32'ha5);
    head(8'h42, 4'h1);
    wr(OFF_ALARM, 32'h99);
    head(8'h42, 4'h2);
    wr(OFF_ALARM, 32'h0);
    head(8'h99, 4'h1);
    wr(OFF_ALARM, 32'h0);
    head(CODE_NONE, 4'h0);
    fire(10'h201);
    head(CODE_INTR, 4'h2);
    wr(OFF_ALARM, 32'h0);
    head(CODE_BATT, 4'h1);
    wr(OFF_CTRL, 32'h7);
    hd_unit <= 4'hc;
    fire(10'h004);
    rd(OFF_AUX);
    chk("aux unit c", 32'h1000, q & 32'hffff);
    wr(OFF_CTRL, 32'h7);
    $display("test queue done");
    scan_on <= 1'b0;
    repeat (80) @(posedge mclk);
    head(CODE_OVR, 4'h1);
    chk("overrun runs", 32'h7, {29'h0, exec_en, run_led, run_out});
    scan_on <= 1'b1;
    repeat (20) @(posedge mclk);
    wr(OFF_CTRL, 32'h7);
    i_cec_console.xfer(1'b0, 8'h40, 32'h0, q, err);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, q);
    $display("test overrun done");
    fatal_err <= 1'b1;
    repeat (8) @(posedge mclk);
    chk("fatal leds", 32'h2, {30'h0, alarm_error_indicator, run_out});
    repeat (5) @(posedge mclk);
    chk("fatal steady", 32'h2, {30'h0, alarm_error_indicator, run_out});
    $display("test fatal done");
    test_done();
  end
endmodule
`default_nettype wire
